// ### logic/abl_autobaud.sv
// autobaud measurement, reload calculation and acknowledge transmitter
`timescale 1ns/1ns
module abl_autobaud
   import abl_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic sector_check_failed,
   input wire logic serial_receive_pin,
   output logic serial_transmit_pin,
   output logic [ABL_CNT_W-1:0] measured_bit_count,
   output logic [ABL_RELOAD_W-1:0] baud_reload_value,
   output logic baud_gen_enable,
   output logic ack_busy,
   output logic command_phase
);
   // ----------------------------------------
   // state and datapath registers, with their combinational nets
   // ----------------------------------------
   abl_state_type state;
   logic [3:0] prescale;
   logic [ABL_CNT_W-1:0] measure_timer_count;
   logic rx_prev;
   logic [ABL_RELOAD_W-1:0] gen_count;
   logic [4:0] os_count;
   logic bit_tick;
   logic [3:0] bit_index;
   logic [ABL_FRAME_BITS-1:0] shifter;
   logic [23:0] product;
   logic [11:0] quotient;
   logic [10:0] next_reload;
   logic prescale_wrap;
   logic gen_wrap;
   logic frame_end;

   // ----------------------------------------
   // reload arithmetic
   // ----------------------------------------
   always_comb begin
      product = 24'(measure_timer_count) * 24'(ABL_SCALE);
      quotient = product[23:ABL_SHIFT] + 12'(product[ABL_SHIFT-1]);
      // counts beyond the host floor wrap here, as the rate limit warns
      next_reload = ABL_RELOAD_TOP - quotient[10:0];
   end

   // ----------------------------------------
   // shared strobes
   // ----------------------------------------
   assign prescale_wrap = (prescale == ABL_PRESCALE_LAST);
   assign gen_wrap = (gen_count == '1);
   assign frame_end = bit_tick && (bit_index == ABL_FRAME_LAST);

   // ----------------------------------------
   // sequencing
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= ABL_IDLE;
      end else begin
         unique case (state)
            ABL_IDLE: begin
               if (sector_check_failed) begin
                  state <= ABL_WAIT_START;
               end
            end
            ABL_WAIT_START: begin
               if (rx_prev && !serial_receive_pin) begin
                  state <= ABL_MEASURE;
               end
            end
            ABL_MEASURE: begin
               if (serial_receive_pin) begin
                  state <= ABL_CALC;
               end
            end
            ABL_CALC: begin
               state <= ABL_SEND;
            end
            ABL_SEND: begin
               if (frame_end) begin
                  state <= ABL_DONE;
               end
            end
            ABL_DONE: begin
               // no success check: only a reset brings the loader back
               state <= ABL_DONE;
            end
            default: state <= ABL_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // receive edge detector
   // ----------------------------------------
   // reset to the idle level, so release gives no false start edge
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rx_prev <= 1'b1;
      end else begin
         rx_prev <= serial_receive_pin;
      end
   end

   // ----------------------------------------
   // measurement timer
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         prescale <= 4'h0;
      end else if (state == ABL_WAIT_START) begin
         prescale <= 4'h0;
      end else if (state == ABL_MEASURE && !serial_receive_pin) begin
         prescale <= prescale_wrap ? 4'h0 : prescale + 4'h1;
      end
   end

   // saturates rather than wraps, so a long byte cannot alias a short one
   always_ff @(posedge core_clk) begin
      if (srst) begin
         measure_timer_count <= '0;
      end else if (state == ABL_WAIT_START) begin
         measure_timer_count <= '0;
      end else if (state == ABL_MEASURE && !serial_receive_pin && prescale_wrap) begin
         if (measure_timer_count != '1) begin
            measure_timer_count <= measure_timer_count + 1'b1;
         end
      end
   end

   // ----------------------------------------
   // latched results
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         measured_bit_count <= '0;
      end else if (state == ABL_CALC) begin
         measured_bit_count <= measure_timer_count;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         baud_reload_value <= '0;
      end else if (state == ABL_CALC) begin
         baud_reload_value <= next_reload[ABL_RELOAD_W-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         baud_gen_enable <= 1'b0;
      end else if (state == ABL_CALC) begin
         baud_gen_enable <= 1'b1;
      end
   end

   // ----------------------------------------
   // baud generator: reload..1023, then /32
   // ----------------------------------------
   // parked at all ones so the first enabled edge loads the reload value;
   // the first bit is then short by at most one generator period
   always_ff @(posedge core_clk) begin
      if (srst || !baud_gen_enable) begin
         gen_count <= '1;
      end else if (gen_wrap) begin
         gen_count <= baud_reload_value;
      end else begin
         gen_count <= gen_count + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst || !baud_gen_enable) begin
         os_count <= 5'h0;
      end else if (gen_wrap) begin
         os_count <= os_count + 5'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst || !baud_gen_enable) begin
         bit_tick <= 1'b0;
      end else begin
         bit_tick <= gen_wrap && (os_count == ABL_OVERSAMPLE_LAST);
      end
   end

   // ----------------------------------------
   // acknowledge transmitter, 8N2
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         shifter <= '1;
      end else if (state == ABL_CALC) begin
         shifter <= {2'b11, ABL_ACK_BYTE, 1'b0};
      end else if (state == ABL_SEND && bit_tick) begin
         shifter <= {1'b1, shifter[ABL_FRAME_BITS-1:1]};
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         bit_index <= 4'h0;
      end else if (state == ABL_CALC) begin
         bit_index <= 4'h0;
      end else if (state == ABL_SEND && bit_tick) begin
         bit_index <= bit_index + 4'h1;
      end
   end

   // registered, so the line cannot glitch while state and shifter move
   always_ff @(posedge core_clk) begin
      if (srst) begin
         serial_transmit_pin <= 1'b1;
      end else if (state == ABL_CALC) begin
         serial_transmit_pin <= 1'b0;
      end else if (state == ABL_SEND) begin
         if (bit_tick) begin
            serial_transmit_pin <= frame_end ? 1'b1 : shifter[1];
         end
      end else begin
         serial_transmit_pin <= 1'b1;
      end
   end

   // ----------------------------------------
   // status outputs
   // ----------------------------------------
   assign ack_busy = (state == ABL_SEND);
   assign command_phase = (state == ABL_DONE);
endmodule

// ### logic/abl_pkg.sv
// constants for the autobaud synchronisation loader
package abl_pkg;
   localparam int ABL_PRESCALE = 12;
   localparam logic [3:0] ABL_PRESCALE_LAST = 4'hB;
   localparam int ABL_CNT_W = 16;
   localparam int ABL_RELOAD_W = 10;
   localparam logic [7:0] ABL_SCALE = 8'hAB;
   localparam int ABL_SHIFT = 12;
   localparam logic [10:0] ABL_RELOAD_TOP = 11'h400;
   localparam logic [4:0] ABL_OVERSAMPLE_LAST = 5'h1F;
   localparam logic [7:0] ABL_ACK_BYTE = 8'h55;
   localparam int ABL_FRAME_BITS = 11;
   localparam logic [3:0] ABL_FRAME_LAST = 4'hA;

   typedef enum logic [5:0] {
      ABL_IDLE = 6'h01,
      ABL_WAIT_START = 6'h02,
      ABL_MEASURE = 6'h04,
      ABL_CALC = 6'h08,
      ABL_SEND = 6'h10,
      ABL_DONE = 6'h20
   } abl_state_type;
endpackage

// ### verif/abl_autobaud_tb.sv
// bench for the autobaud loader
`timescale 1ns/1ns
module abl_autobaud_tb;
   logic core_clk = 1'h0, srst = 1'h1, scf = 1'h0, go = 1'h0, noise = 1'h1, hrx, tx;
   logic [15:0] low_cyc = 16'h0000;
   logic [15:0] cnt;
   logic [9:0] rel;
   logic en, busy, cmd;
   logic [10:0] frame;
   int fails = 0, total_checks = 0;
   always #5 core_clk = ~core_clk;
   abl_host HOST (.core_clk(core_clk), .go(go), .low_cyc(low_cyc), .rxd(hrx));
   abl_autobaud DUT (.core_clk(core_clk), .srst(srst), .sector_check_failed(scf),
      .serial_receive_pin(hrx & noise), .serial_transmit_pin(tx),
      .measured_bit_count(cnt), .baud_reload_value(rel), .baud_gen_enable(en),
      .ack_busy(busy), .command_phase(cmd));
   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      total_checks++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic t_early();
      @(posedge core_clk) noise <= 1'h0;
      repeat (300) @(posedge core_clk);
      noise <= 1'h1;
      repeat (5) @(posedge core_clk);
      chk("early_en", 16'h0, {15'h0, en});
      chk("early_cnt", 16'h0, cnt);
      chk("early_tx", 16'h1, {15'h0, tx});
   endtask
   task automatic run_sync(logic [15:0] low, logic [15:0] exp_cnt, logic [9:0] exp_rel,
      int bit_cyc);
      int i;
      @(posedge core_clk) low_cyc <= low;
      @(posedge core_clk) go <= 1'h1;
      for (i = 0; i < 6000 && busy !== 1'h1; i++) @(posedge core_clk);
      if (i == 6000) begin
         fails++;
         end_sim();
      end
      chk("count", exp_cnt, cnt);
      chk("reload", {6'h0, exp_rel}, {6'h0, rel});
      chk("enable", 16'h1, {15'h0, en});
      repeat (bit_cyc / 2 - 4) @(posedge core_clk);
      for (i = 0; i < 11; i++) begin
         #1 frame[i] = tx;
         repeat (bit_cyc) @(posedge core_clk);
      end
      chk("ack", 16'h06AA, {5'h0, frame});
      for (i = 0; i < 300 && cmd !== 1'h1; i++) @(posedge core_clk);
      chk("cmd", 16'h1, {15'h0, cmd});
      chk("idle_tx", 16'h1, {15'h0, tx});
      go <= 1'h0;
   endtask
   task automatic t_sync();
      @(posedge core_clk) scf <= 1'h1;
      run_sync(16'h0480, 16'h005F, 10'h3FC, 128);
   endtask
   task automatic t_resync();
      @(posedge core_clk) srst <= 1'h1;
      repeat (4) @(posedge core_clk);
      chk("rst_en", 16'h0, {15'h0, en});
      chk("rst_cmd", 16'h0, {15'h0, cmd});
      chk("rst_tx", 16'h1, {15'h0, tx});
      srst <= 1'h0;
      repeat (2) @(posedge core_clk);
      chk("rst_rel", 16'h0, {6'h0, rel});
      run_sync(16'h0936, 16'h00C4, 10'h3F8, 256);
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      srst <= 1'h0;
      t_early();
      t_sync();
      t_resync();
      end_sim();
   end
endmodule

// ### verif/abl_checker.sv
// port assertions for the autobaud loader
`timescale 1ns/1ns
module abl_checker
   import abl_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic sector_check_failed,
   input wire logic serial_receive_pin,
   input wire logic serial_transmit_pin,
   input wire logic [15:0] measured_bit_count,
   input wire logic [9:0] baud_reload_value,
   input wire logic baud_gen_enable,
   input wire logic ack_busy,
   input wire logic command_phase
);
   logic [23:0] prod;
   assign prod = 24'(measured_bit_count) * 24'hAB;
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   sequence s_start_bit;
      !serial_transmit_pin [*8];
   endsequence
   property p_quiet;
      !sector_check_failed |-> serial_transmit_pin && !baud_gen_enable;
   endproperty
   a_quiet: assert property (p_quiet) else $error("early activity");
   property p_reload;
      $rose(baud_gen_enable) |-> baud_reload_value ==
         10'(11'h400 - 11'(prod >> 12) - 11'(prod[11]));
   endproperty
   a_reload: assert property (p_reload) else $error("bad reload");
   property p_ack_start;
      $rose(ack_busy) |-> baud_gen_enable ##0 s_start_bit;
   endproperty
   a_ack_start: assert property (p_ack_start) else $error("bad start");
   property p_cmd;
      $fell(ack_busy) |-> ##[0:1] command_phase;
   endproperty
   a_cmd: assert property (p_cmd) else $error("no command phase");
   property p_cmd_stays;
      command_phase |=> command_phase && serial_transmit_pin && !ack_busy;
   endproperty
   a_cmd_stays: assert property (p_cmd_stays) else $error("left command");
   property p_hold;
      baud_gen_enable |=> $stable(baud_reload_value) && $stable(measured_bit_count);
   endproperty
   a_hold: assert property (p_hold) else $error("value moved");
   property p_en_stays;
      baud_gen_enable |=> baud_gen_enable;
   endproperty
   a_en_stays: assert property (p_en_stays) else $error("enable lost");
   property p_busy_en;
      ack_busy |-> baud_gen_enable && !command_phase;
   endproperty
   a_busy_en: assert property (p_busy_en) else $error("busy early");
endmodule
bind abl_autobaud abl_checker chk (.*);

// ### verif/abl_host.sv
// host model: sends the zero test byte
`timescale 1ns/1ns
module abl_host
(
   input wire logic core_clk,
   input wire logic go,
   input wire logic [15:0] low_cyc,
   output logic rxd
);
   initial rxd = 1'h1;
   always @(posedge go) begin
      rxd <= 1'h0; // start plus eight zero bits, rate above minimum
      repeat (low_cyc) @(posedge core_clk);
      rxd <= 1'h1; // stop bits then idle high
   end
endmodule
